/* src/drv_cfg_pkg.sv */
// constants for the clock output driver configuration registers
package drv_cfg_pkg;
  // ----------------------------------------------------------------
  // register map (printed offsets are indices, byte address is 4x)
  // ----------------------------------------------------------------
  localparam logic [7:0] OUTPUT0_DRIVER_CONTROL_IDX = 8'h1f;
  localparam logic [7:0] OUTPUT1_DRIVER_CONTROL_IDX = 8'h20;
  localparam logic [7:0] OUTPUT0_DRIVER_CONTROL_ADDR = 8'h7c;
  localparam logic [7:0] OUTPUT1_DRIVER_CONTROL_ADDR = 8'h80;
  localparam int NUM_CH = 2;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RESERVED_BIT_POS = 7;
  localparam int FMT_LSB = 5;
  localparam int SETTING_A_LSB = 3;
  localparam int SETTING_B_LSB = 1;
  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CH0_RESET = 8'hb0;
  localparam logic [7:0] CH1_RESET = 8'h30;
  localparam logic [7:0] CH0_WR_MASK = 8'hfe;
  localparam logic [7:0] CH1_WR_MASK = 8'h7e;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_DISABLED = 2'h0;
  localparam logic [1:0] FMT_AC_DIFF = 2'h1;
  localparam logic [1:0] FMT_HCSL = 2'h2;
  localparam logic [1:0] FMT_CMOS = 2'h3;
  localparam logic [1:0] PIN_OFF_TRISTATE = 2'h0;
  localparam logic [1:0] LOAD_TRISTATE = 2'h0;
  localparam logic [4:0] TAIL_MA_0 = 5'h04;
  localparam logic [4:0] TAIL_MA_1 = 5'h06;
  localparam logic [4:0] TAIL_MA_2 = 5'h08;
  localparam logic [4:0] TAIL_MA_3_HCSL = 5'h10;
  localparam logic [4:0] TAIL_MA_3_AC = 5'h08;
  localparam logic [4:0] TAIL_MA_OFF = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* src/drv_regs_if.sv */
// carrier between the bus slave and the control register store
`timescale 1ns/1ps
`default_nettype none
interface drv_regs_if;
  logic wr_en;
  logic wr_idx;
  logic [7:0] wr_data;
  logic rd_en;
  logic rd_idx;
  logic [7:0] rd_data;
  logic [7:0] ctl [2];
  modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data, ctl);
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data, ctl);
endinterface
`default_nettype wire

/* src/drv_ctl_store.sv */
// storage for the two driver control registers
`timescale 1ns/1ps
`default_nettype none
module drv_ctl_store (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // access port
  drv_regs_if.store regs
);
  logic [7:0] ctl_ff [2];
  logic [7:0] rd_data_ff;
  localparam logic [7:0] RESET_VAL [2] = '{drv_cfg_pkg::CH0_RESET, drv_cfg_pkg::CH1_RESET};
  localparam logic [7:0] WR_MASK [2] = '{drv_cfg_pkg::CH0_WR_MASK, drv_cfg_pkg::CH1_WR_MASK};

  // ----------------------------------------------------------------
  // per channel register
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < drv_cfg_pkg::NUM_CH; ch++) begin : g_ch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_ff[ch] <= RESET_VAL[ch]; // RULE_02 RULE_03 RULE_05 RULE_06
      end else if (regs.wr_en && (regs.wr_idx == 1'(ch))) begin
        ctl_ff[ch] <= regs.wr_data & WR_MASK[ch]; // RULE_08
      end
    end
    assign regs.ctl[ch] = ctl_ff[ch];
  end

  // ----------------------------------------------------------------
  // registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_ff <= 8'h00;
    end else if (regs.rd_en) begin
      rd_data_ff <= ctl_ff[regs.rd_idx];
    end
  end
  assign regs.rd_data = rd_data_ff;
endmodule
`default_nettype wire

/* src/clk_out_drv_cfg.sv */
// axi4-lite register bank driving clock output channels 0 and 1
// Behaviour
// RULE_01: format field selects disabled, AC diff, HCSL, CMOS
// RULE_02: format field resets to AC differential
// RULE_03: CMOS setting A drives true pin, resets two
// RULE_04: differential setting A picks tail current
// RULE_05: setting B: HCSL load or complement pin
// RULE_06: channel 1 mirrors channel 0 independently
// RULE_07: software should write zero to reserved bit
// RULE_08: unused bits read zero, fields read back
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module clk_out_drv_cfg (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // analog driver controls, two bits per channel except drv_enable (one bit) and tail_ma (five bits)
  output logic [1:0] drv_enable,
  output logic [3:0] drv_format,
  output logic [9:0] tail_ma,
  output logic [3:0] hcsl_load,
  output logic [3:0] cmos_p_ctl,
  output logic [3:0] cmos_n_ctl
);
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_RESP = 2'b10
  } rd_state_e;

  drv_regs_if regs ();
  drv_ctl_store u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .regs(regs.store)
  );

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_held_ff, w_held_ff, rd_mapped_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  rd_state_e rd_state_ff;
  logic do_write, wr_mapped, ar_take;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_mapped = (awaddr_ff == drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR) ||
                     (awaddr_ff == drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR);
  assign regs.wr_en = do_write && wr_mapped && wstrb0_ff;
  assign regs.wr_idx = (awaddr_ff == drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR);
  assign regs.wr_data = wdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b1;
      awaddr_ff <= awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end else if (!aw_held_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else if (wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b1;
      wdata_ff <= wdata[7:0];
      wstrb0_ff <= wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end else if (!w_held_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= drv_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? drv_cfg_pkg::RESP_OKAY : drv_cfg_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign ar_take = arvalid && arready_ff;
  assign regs.rd_en = ar_take;
  assign regs.rd_idx = (araddr == drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
    end else if (rd_state_ff == RD_IDLE) begin
      arready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= RD_IDLE;
      rd_mapped_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= drv_cfg_pkg::RESP_OKAY;
    end else begin
      case (rd_state_ff)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state_ff <= RD_FETCH;
            rd_mapped_ff <= (araddr == drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR) ||
                            (araddr == drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR);
          end
        end
        RD_FETCH: begin
          rd_state_ff <= RD_RESP;
          rvalid_ff <= 1'b1;
          rdata_ff <= rd_mapped_ff ? {24'h00_0000, regs.rd_data} : 32'h0000_0000; // RULE_08
          rresp_ff <= rd_mapped_ff ? drv_cfg_pkg::RESP_OKAY : drv_cfg_pkg::RESP_SLVERR;
        end
        RD_RESP: begin
          if (rready) begin
            rvalid_ff <= 1'b0;
            rd_state_ff <= RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= RD_IDLE;
        end
      endcase
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ----------------------------------------------------------------
  // driver control decode, one copy per channel
  // ----------------------------------------------------------------
  logic [1:0] fmt [2];
  logic [1:0] set_a [2];
  logic [1:0] set_b [2];

  for (genvar ch = 0; ch < drv_cfg_pkg::NUM_CH; ch++) begin : g_drv
    logic [4:0] nxt_tail;
    assign fmt[ch] = regs.ctl[ch][drv_cfg_pkg::FMT_LSB +: 2];
    assign set_a[ch] = regs.ctl[ch][drv_cfg_pkg::SETTING_A_LSB +: 2];
    assign set_b[ch] = regs.ctl[ch][drv_cfg_pkg::SETTING_B_LSB +: 2];

    always_comb begin
      nxt_tail = drv_cfg_pkg::TAIL_MA_OFF;
      if (fmt[ch] == drv_cfg_pkg::FMT_AC_DIFF || fmt[ch] == drv_cfg_pkg::FMT_HCSL) begin
        case (set_a[ch]) // RULE_04
          2'h0: nxt_tail = drv_cfg_pkg::TAIL_MA_0;
          2'h1: nxt_tail = drv_cfg_pkg::TAIL_MA_1;
          2'h2: nxt_tail = drv_cfg_pkg::TAIL_MA_2;
          default: nxt_tail = (fmt[ch] == drv_cfg_pkg::FMT_HCSL) ?
                              drv_cfg_pkg::TAIL_MA_3_HCSL : drv_cfg_pkg::TAIL_MA_3_AC;
        endcase
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        drv_enable[ch] <= 1'b0;
        drv_format[2*ch +: 2] <= drv_cfg_pkg::FMT_DISABLED;
        tail_ma[5*ch +: 5] <= drv_cfg_pkg::TAIL_MA_OFF;
        hcsl_load[2*ch +: 2] <= drv_cfg_pkg::LOAD_TRISTATE;
        cmos_p_ctl[2*ch +: 2] <= drv_cfg_pkg::PIN_OFF_TRISTATE;
        cmos_n_ctl[2*ch +: 2] <= drv_cfg_pkg::PIN_OFF_TRISTATE;
      end else begin
        drv_enable[ch] <= (fmt[ch] != drv_cfg_pkg::FMT_DISABLED); // RULE_01 RULE_06
        drv_format[2*ch +: 2] <= fmt[ch]; // RULE_01
        tail_ma[5*ch +: 5] <= nxt_tail; // RULE_04
        hcsl_load[2*ch +: 2] <= (fmt[ch] == drv_cfg_pkg::FMT_HCSL) ?
                                set_b[ch] : drv_cfg_pkg::LOAD_TRISTATE; // RULE_05
        cmos_p_ctl[2*ch +: 2] <= (fmt[ch] == drv_cfg_pkg::FMT_CMOS) ?
                                 set_a[ch] : drv_cfg_pkg::PIN_OFF_TRISTATE; // RULE_03
        cmos_n_ctl[2*ch +: 2] <= (fmt[ch] == drv_cfg_pkg::FMT_CMOS) ?
                                 set_b[ch] : drv_cfg_pkg::PIN_OFF_TRISTATE; // RULE_05
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_disabled_off; // RULE_01
    @(posedge aclk) disable iff (!aresetn)
      (fmt[0] == drv_cfg_pkg::FMT_DISABLED) |=> !drv_enable[0] && tail_ma[4:0] == 5'h00;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled driver on"); // RULE_01

  property p_reset_fmt; // RULE_02
    @(posedge aclk) $rose(aresetn) |-> fmt[0] == drv_cfg_pkg::FMT_AC_DIFF &&
      fmt[1] == drv_cfg_pkg::FMT_AC_DIFF ##1 drv_enable == 2'b11;
  endproperty
  a_reset_fmt: assert property (p_reset_fmt) else $error("bad format after reset"); // RULE_02

  property p_cmos_p; // RULE_03
    @(posedge aclk) disable iff (!aresetn)
      (fmt[0] == drv_cfg_pkg::FMT_CMOS) |=> cmos_p_ctl[1:0] == $past(set_a[0]);
  endproperty
  a_cmos_p: assert property (p_cmos_p) else $error("true pin control wrong"); // RULE_03

  property p_hcsl_tail; // RULE_04
    @(posedge aclk) disable iff (!aresetn)
      (fmt[1] == drv_cfg_pkg::FMT_HCSL && set_a[1] == 2'h3) |=> tail_ma[9:5] == 5'h10;
  endproperty
  a_hcsl_tail: assert property (p_hcsl_tail) else $error("hcsl tail not 16 mA"); // RULE_04

  property p_load; // RULE_05
    @(posedge aclk) disable iff (!aresetn)
      (fmt[0] == drv_cfg_pkg::FMT_HCSL) |=> hcsl_load[1:0] == $past(set_b[0]) &&
      cmos_n_ctl[1:0] == 2'h0;
  endproperty
  a_load: assert property (p_load) else $error("hcsl load wrong"); // RULE_05

  property p_ch1_reset; // RULE_06
    @(posedge aclk) $rose(aresetn) |-> set_a[1] == 2'h2 && set_b[1] == 2'h0 &&
      set_a[0] == 2'h2;
  endproperty
  a_ch1_reset: assert property (p_ch1_reset) else $error("setting reset value wrong"); // RULE_06

  property p_read_zero; // RULE_08
    @(posedge aclk) disable iff (!aresetn)
      $rose(rvalid_ff) |-> rdata_ff[0] == 1'b0 && rdata_ff[31:8] == 24'h00_0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unused read bits not zero"); // RULE_08

  property p_write_back; // RULE_08
    @(posedge aclk) disable iff (!aresetn)
      regs.wr_en && !regs.wr_idx |=> regs.ctl[0] == ($past(regs.wr_data) & 8'hfe);
  endproperty
  a_write_back: assert property (p_write_back) else $error("write did not store"); // RULE_08
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the clock output driver configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {logic [31:0] d; logic [1:0] r;} rd_exp_s;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, drv_enable;
  logic [3:0] drv_format, hcsl_load, cmos_p_ctl, cmos_n_ctl;
  logic [9:0] tail_ma;
  logic [7:0] exp_reg [2];
  logic [1:0] wq [$];
  rd_exp_s rq [$];
  int err_total, comparisons;
  clk_out_drv_cfg u_clk_out_drv_cfg (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .drv_enable(drv_enable),
    .drv_format(drv_format), .tail_ma(tail_ma), .hcsl_load(hcsl_load),
    .cmos_p_ctl(cmos_p_ctl), .cmos_n_ctl(cmos_n_ctl));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick_guard(inout int n);
    n++;
    if (n > 50) begin
      err_total++;
      results();
    end
  endtask
  // answers are compared in the order they were requested
  always @(posedge aclk) begin
    if (aresetn && bvalid && bready) begin
      if (wq.size() == 0) check("bresp_unexpected", 32'h1, 32'h0);
      else check("bresp", {30'h0, bresp}, {30'h0, wq.pop_front()});
    end
    if (aresetn && rvalid && rready) begin
      if (rq.size() == 0) check("rvalid_unexpected", 32'h1, 32'h0);
      else begin
        check("rdata", rdata, rq[0].d);
        check("rresp", {30'h0, rresp}, {30'h0, rq[0].r});
        void'(rq.pop_front());
      end
    end
  end
  // ----------------------------------------------------------------
  // bus master tasks
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    bit aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    wq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      tick_guard(n);
    end
    do begin
      @(posedge aclk);
      tick_guard(n);
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    rd_exp_s e;
    n = 0;
    e.d = ed;
    e.r = er;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      tick_guard(n);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      tick_guard(n);
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // expected driver controls from the stored bytes
  // ----------------------------------------------------------------
  task automatic chk_drv();
    logic [1:0] f, sa, sb, ld, cp, cn;
    logic [4:0] t;
    @(negedge aclk);
    for (int ch = 0; ch < 2; ch++) begin
      f = exp_reg[ch][6:5];
      sa = exp_reg[ch][4:3];
      sb = exp_reg[ch][2:1];
      t = (sa == 2'h0) ? 5'h04 : (sa == 2'h1) ? 5'h06 : (sa == 2'h2) ? 5'h08 :
          (f == 2'h2) ? 5'h10 : 5'h08;
      if (f == 2'h0 || f == 2'h3) t = 5'h00;
      ld = (f == 2'h2) ? sb : 2'h0;
      cp = (f == 2'h3) ? sa : 2'h0;
      cn = (f == 2'h3) ? sb : 2'h0;
      check("drv_enable", {31'h0, drv_enable[ch]}, {31'h0, f != 2'h0});
      check("drv_format", {30'h0, drv_format[2*ch +: 2]}, {30'h0, f});
      check("tail_ma", {27'h0, tail_ma[5*ch +: 5]}, {27'h0, t});
      check("hcsl_load", {30'h0, hcsl_load[2*ch +: 2]}, {30'h0, ld});
      check("cmos_p_ctl", {30'h0, cmos_p_ctl[2*ch +: 2]}, {30'h0, cp});
      check("cmos_n_ctl", {30'h0, cmos_n_ctl[2*ch +: 2]}, {30'h0, cn});
    end
    @(posedge aclk);
  endtask
  task automatic reset_and_check(input int cycles);
    aresetn <= 1'b0;
    repeat (cycles) @(posedge aclk);
    aresetn <= 1'b1;
    exp_reg[0] = {1'b1, drv_cfg_pkg::FMT_AC_DIFF, 2'h2, 2'h0, 1'b0};
    exp_reg[1] = {1'b0, drv_cfg_pkg::FMT_AC_DIFF, 2'h2, 2'h0, 1'b0};
    repeat (2) @(posedge aclk);
    chk_drv();
    axi_read(drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR, {24'h0, exp_reg[0]}, 2'h0);
    axi_read(drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR, {24'h0, exp_reg[1]}, 2'h0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [7:0] a;
    int ch;
    err_total = 0;
    comparisons = 0;
    {awaddr, araddr, awprot, arprot, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = '0;
    wstrb = '0;
    aresetn = 1'b0;
    void'($urandom(31));
    @(posedge aclk);
    reset_and_check(4);
    // every field combination on each channel, other bits random
    for (int i = 0; i < 128; i++) begin
      ch = i % 2;
      d = $urandom;
      d[6:1] = i[6:1];
      a = ch ? drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR : drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR;
      axi_write(a, d, 4'hf, 2'h0);
      exp_reg[ch] = d[7:0] & (ch ? 8'h7e : 8'hfe);
      chk_drv();
      axi_read(a, {24'h0, exp_reg[ch]}, 2'h0);
    end
    // software clears the spare top bit of channel 0
    axi_write(drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR, 32'h0000004c, 4'hf, 2'h0);
    exp_reg[0] = 8'h4c;
    axi_read(drv_cfg_pkg::OUTPUT0_DRIVER_CONTROL_ADDR, 32'h0000004c, 2'h0);
    // strobe low: no store
    axi_write(drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR, 32'h000000ff, 4'he, 2'h0);
    axi_read(drv_cfg_pkg::OUTPUT1_DRIVER_CONTROL_ADDR, {24'h0, exp_reg[1]}, 2'h0);
    // unmapped places
    axi_write(8'h84, 32'h000000ff, 4'hf, drv_cfg_pkg::RESP_SLVERR);
    axi_read(8'h84, 32'h0, drv_cfg_pkg::RESP_SLVERR);
    axi_read(8'h00, 32'h0, drv_cfg_pkg::RESP_SLVERR);
    chk_drv();
    reset_and_check(2);
    repeat (2) @(posedge aclk);
    results();
  end
endmodule
`default_nettype wire
